/* pfl_event_window.sv */
/*
  Counts events that arrive as toggles from the link clock domain and
  trips once a fixed number of them fall inside one counting window.
  Assumes the toggle changes no faster than every second system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pfl_event_window #(
  parameter int LIMIT = 20
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic toggle_i,
  input wire logic window_end_i,
  input wire logic enable_i,
  output logic trip_o
);
  localparam logic [pfl_pkg::CNT_W-1:0] LIMIT_C = LIMIT[pfl_pkg::CNT_W-1:0];

  logic [2:0] sync_r;
  logic [pfl_pkg::CNT_W-1:0] count_r;
  logic seen;

  // ==========================================================
  // Toggle crossing
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], toggle_i};
    end
  end

  assign seen = sync_r[2] ^ sync_r[1];

  // ==========================================================
  // Window counter, saturating at the limit
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_r <= '0;
    end else if (window_end_i) begin
      count_r <= {{(pfl_pkg::CNT_W-1){1'b0}}, seen};
    end else if (seen && count_r != LIMIT_C) begin
      count_r <= count_r + 1'b1;
    end
  end

  assign trip_o = enable_i && (count_r == LIMIT_C);

  a_window_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    window_end_i |=> count_r <= 1)
    else $error("Event count not restarted at window end");

  a_trip_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (count_r == LIMIT_C) && !window_end_i |=> count_r == LIMIT_C)
    else $error("Reached limit lost inside window");
endmodule
`default_nettype wire

/* pfl_host_model.sv */
/*
  Behavioural management host that drives the strobe register port of the
  register slice and reads it back.
  Assumes strobes are sampled on the rising edge of sys_clk_i and that read
  data comes back exactly one cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module pfl_host_model (
  input wire logic sys_clk_i,
  output logic [4:0] mgmt_addr_o,
  output logic mgmt_wr_o,
  output logic mgmt_rd_o,
  output logic [15:0] mgmt_wdata_o,
  input wire logic [15:0] mgmt_rdata_i,
  input wire logic mgmt_rvalid_i
);
  // ==========================================================
  // Port idle values
  initial begin
    mgmt_addr_o = 5'h00;
    mgmt_wr_o = 1'b0;
    mgmt_rd_o = 1'b0;
    mgmt_wdata_o = 16'h0000;
  end

  // ==========================================================
  // Register cycles
  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    mgmt_addr_o <= a;
    mgmt_wdata_o <= d;
    mgmt_wr_o <= 1'b1;
    @(posedge sys_clk_i);
    mgmt_wr_o <= 1'b0;
    // Released data shows the inverse so stale values cannot pass as valid.
    mgmt_wdata_o <= ~d;
  endtask

  task automatic read_reg(input logic [4:0] a, output logic [15:0] d, output logic ok);
    @(posedge sys_clk_i);
    mgmt_addr_o <= a;
    mgmt_rd_o <= 1'b1;
    @(posedge sys_clk_i);
    mgmt_rd_o <= 1'b0;
    #1;
    ok = mgmt_rvalid_i;
    d = mgmt_rdata_i;
  endtask

  // Selects the vendor device, loads the pointer, then sets the mode.
  task automatic open_window(input logic [1:0] func, input logic [15:0] ptr);
    write_reg(pfl_pkg::ADDR_CTRL, {pfl_pkg::FUNC_ADDR, 9'h000, pfl_pkg::SEL_VENDOR});
    write_reg(pfl_pkg::ADDR_IDATA, ptr);
    write_reg(pfl_pkg::ADDR_CTRL, {func, 9'h000, pfl_pkg::SEL_VENDOR});
  endtask
endmodule
`default_nettype wire

/* pfl_mgmt_regs.sv */
/*
  Management register slice: indirect extended-register window, software
  strap control three and the fast link-down detector with its status.
  Assumes a register port from a serial management engine on sys_clk_i
  and link-side event signals on link_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module pfl_mgmt_regs (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic link_clk_i,
  input wire logic [4:0] mgmt_addr_i,
  input wire logic mgmt_wr_i,
  input wire logic mgmt_rd_i,
  input wire logic [15:0] mgmt_wdata_i,
  output logic [15:0] mgmt_rdata_o,
  output logic mgmt_rvalid_o,
  input wire logic rx_err_i,
  input wire logic mlt3_viol_i,
  input wire logic snr_low_i,
  input wire logic energy_loss_i,
  input wire logic descr_unlock_i,
  output logic link_drop_o,
  output logic bypass_4b5b_o,
  output logic mirror_en_o,
  input wire logic tdi_txd4_i,
  output logic tx_sym4_o,
  input wire logic rx_sym4_i,
  output logic receive_error_pin_o,
  input wire logic tx_line_i,
  output logic rx_line_o,
  output logic transmit_pair_tx_o,
  output logic receive_pair_tx_o,
  input wire logic transmit_pair_rx_i,
  input wire logic receive_pair_rx_i
);
  logic [1:0] func_r;
  logic [4:0] dev_sel_r;
  logic [15:0] ptr_r;
  logic [15:0] ext_mem_r [pfl_pkg::EXT_DEPTH];
  logic [15:0] strap_r;
  logic [4:0] status_r;
  logic [15:0] rdata_r;
  logic rvalid_r;
  logic drop_r;
  logic [9:0] win_cnt_r;
  logic win_end;
  logic win_ok;
  logic idata_wr;
  logic idata_rd;
  logic ptr_inc;
  logic ptr_in_range;
  logic [pfl_pkg::EXT_IDX_W-1:0] ptr_idx;
  logic [15:0] ext_rd;
  logic [15:0] rdata_nxt;
  logic [4:0] cause;
  logic [1:0] lvl_s1_r;
  logic [1:0] lvl_s2_r;
  logic trip_rx;
  logic trip_mlt3;
  logic trip_snr;
  logic [2:0] ev_tog_r;
  logic [1:0] cfg_s1_r;
  logic [1:0] cfg_s2_r;
  logic tx_sym4_r;
  logic err_pin_r;
  logic rx_line_r;
  logic tp_tx_r;
  logic rp_tx_r;

  // ==========================================================
  // Access decode
  assign win_ok = (dev_sel_r == pfl_pkg::SEL_VENDOR);
  assign idata_wr = mgmt_wr_i && (mgmt_addr_i == pfl_pkg::ADDR_IDATA) && win_ok;
  assign idata_rd = mgmt_rd_i && (mgmt_addr_i == pfl_pkg::ADDR_IDATA) && win_ok;
  assign ptr_in_range = (ptr_r < pfl_pkg::EXT_DEPTH_W);
  assign ptr_idx = ptr_r[pfl_pkg::EXT_IDX_W-1:0];
  assign ext_rd = ptr_in_range ? ext_mem_r[ptr_idx] : 16'h0000;

  always_comb begin
    ptr_inc = 1'b0;
    unique case (func_r)
      pfl_pkg::FUNC_ADDR: ptr_inc = 1'b0;
      pfl_pkg::FUNC_DATA: ptr_inc = 1'b0;
      pfl_pkg::FUNC_INC_RW: ptr_inc = idata_wr || idata_rd;
      pfl_pkg::FUNC_INC_WR: ptr_inc = idata_wr;
    endcase
  end

  // ==========================================================
  // Indirect control register
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      func_r <= 2'h0;
      dev_sel_r <= 5'h00;
    end else if (mgmt_wr_i && mgmt_addr_i == pfl_pkg::ADDR_CTRL) begin
      func_r <= mgmt_wdata_i[pfl_pkg::FUNC_LSB +: 2];
      dev_sel_r <= mgmt_wdata_i[4:0];
    end
  end

  // ==========================================================
  // Extended pointer
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ptr_r <= pfl_pkg::REG_RESET;
    end else if (idata_wr && func_r == pfl_pkg::FUNC_ADDR) begin
      ptr_r <= mgmt_wdata_i;
    end else if (ptr_inc) begin
      ptr_r <= ptr_r + 16'h0001;
    end
  end

  // ==========================================================
  // Extended register storage, writable only through the window
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < pfl_pkg::EXT_DEPTH; i++) begin
        ext_mem_r[i] <= pfl_pkg::REG_RESET;
      end
    end else if (idata_wr && func_r != pfl_pkg::FUNC_ADDR && ptr_in_range) begin
      ext_mem_r[ptr_idx] <= mgmt_wdata_i;
    end
  end

  // ==========================================================
  // Software strap control three
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      strap_r <= pfl_pkg::REG_RESET;
    end else if (mgmt_wr_i && mgmt_addr_i == pfl_pkg::ADDR_STRAP3) begin
      strap_r <= mgmt_wdata_i & pfl_pkg::STRAP_WMASK;
    end
  end

  assign bypass_4b5b_o = strap_r[pfl_pkg::STRAP_BYPASS_BIT];
  assign mirror_en_o = strap_r[pfl_pkg::STRAP_SWAP_BIT] && strap_r[pfl_pkg::STRAP_POL_BIT];

  // ==========================================================
  // Read path
  always_comb begin
    rdata_nxt = 16'h0000;
    unique case (mgmt_addr_i)
      pfl_pkg::ADDR_CTRL: rdata_nxt = {func_r, 9'h000, dev_sel_r};
      pfl_pkg::ADDR_IDATA: begin
        if (win_ok) begin
          rdata_nxt = (func_r == pfl_pkg::FUNC_ADDR) ? ptr_r : ext_rd;
        end
      end
      pfl_pkg::ADDR_STATUS: rdata_nxt = {7'h00, status_r, 4'h0};
      pfl_pkg::ADDR_STRAP3: rdata_nxt = strap_r;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= mgmt_rd_i;
      if (mgmt_rd_i) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign mgmt_rdata_o = rdata_r;
  assign mgmt_rvalid_o = rvalid_r;

  // ==========================================================
  // Fast link-down detection
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      win_cnt_r <= 10'h000;
    end else if (win_end) begin
      win_cnt_r <= 10'h000;
    end else begin
      win_cnt_r <= win_cnt_r + 10'h001;
    end
  end

  assign win_end = (win_cnt_r == pfl_pkg::WINDOW_LAST);

  // Energy and lock-loss levels cross over from the link domain.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lvl_s1_r <= 2'h0;
      lvl_s2_r <= 2'h0;
    end else begin
      lvl_s1_r <= {descr_unlock_i, energy_loss_i};
      lvl_s2_r <= lvl_s1_r;
    end
  end

  pfl_event_window #(
    .LIMIT(pfl_pkg::RX_ERR_LIMIT)
  ) u_rx_err_win (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .toggle_i(ev_tog_r[2]),
    .window_end_i(win_end),
    .enable_i(strap_r[pfl_pkg::STRAP_RX_ERR_BIT]),
    .trip_o(trip_rx)
  );
  pfl_event_window #(
    .LIMIT(pfl_pkg::MLT3_LIMIT)
  ) u_mlt3_win (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .toggle_i(ev_tog_r[1]),
    .window_end_i(win_end),
    .enable_i(strap_r[pfl_pkg::STRAP_MLT3_BIT]),
    .trip_o(trip_mlt3)
  );
  pfl_event_window #(
    .LIMIT(pfl_pkg::SNR_LIMIT)
  ) u_snr_win (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .toggle_i(ev_tog_r[0]),
    .window_end_i(win_end),
    .enable_i(strap_r[pfl_pkg::STRAP_SNR_BIT]),
    .trip_o(trip_snr)
  );

  assign cause[pfl_pkg::CAUSE_DESCR] = strap_r[pfl_pkg::STRAP_DESCR_BIT] && lvl_s2_r[1];
  assign cause[pfl_pkg::CAUSE_RX_ERR] = trip_rx;
  assign cause[pfl_pkg::CAUSE_MLT3] = trip_mlt3;
  assign cause[pfl_pkg::CAUSE_SNR] = trip_snr;
  assign cause[pfl_pkg::CAUSE_ENERGY] = strap_r[pfl_pkg::STRAP_ENERGY_BIT] && lvl_s2_r[0];

  // A cause present in the read cycle survives the clear.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_r <= 5'h00;
      drop_r <= 1'b0;
    end else begin
      drop_r <= |cause;
      if (mgmt_rd_i && mgmt_addr_i == pfl_pkg::ADDR_STATUS) begin
        status_r <= cause;
      end else begin
        status_r <= status_r | cause;
      end
    end
  end

  assign link_drop_o = drop_r;

  // ==========================================================
  // Link clock domain
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ev_tog_r <= 3'h0;
    end else begin
      ev_tog_r <= ev_tog_r ^ {rx_err_i, mlt3_viol_i, snr_low_i};
    end
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_s1_r <= 2'h0;
      cfg_s2_r <= 2'h0;
    end else begin
      cfg_s1_r <= {strap_r[pfl_pkg::STRAP_SWAP_BIT], strap_r[pfl_pkg::STRAP_BYPASS_BIT]};
      cfg_s2_r <= cfg_s1_r;
    end
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_sym4_r <= 1'b0;
      err_pin_r <= 1'b0;
    end else begin
      tx_sym4_r <= cfg_s2_r[0] && tdi_txd4_i;
      err_pin_r <= cfg_s2_r[0] ? rx_sym4_i : rx_err_i;
    end
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_line_r <= 1'b0;
      tp_tx_r <= 1'b0;
      rp_tx_r <= 1'b0;
    end else if (cfg_s2_r[1]) begin
      rx_line_r <= transmit_pair_rx_i;
      tp_tx_r <= 1'b0;
      rp_tx_r <= tx_line_i;
    end else begin
      rx_line_r <= receive_pair_rx_i;
      tp_tx_r <= tx_line_i;
      rp_tx_r <= 1'b0;
    end
  end

  assign tx_sym4_o = tx_sym4_r;
  assign receive_error_pin_o = err_pin_r;
  assign rx_line_o = rx_line_r;
  assign transmit_pair_tx_o = tp_tx_r;
  assign receive_pair_tx_o = rp_tx_r;

  // ==========================================================
  // Checks
  sequence s_data_access;
    (idata_wr || idata_rd) && func_r != pfl_pkg::FUNC_ADDR;
  endsequence
  sequence s_status_read;
    mgmt_rd_i && mgmt_addr_i == pfl_pkg::ADDR_STATUS;
  endsequence

  a_addr_load: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    idata_wr && func_r == pfl_pkg::FUNC_ADDR |=> ptr_r == $past(mgmt_wdata_i))
    else $error("Pointer not loaded in address mode");
  a_ptr_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_data_access and func_r == pfl_pkg::FUNC_DATA |=> $stable(ptr_r))
    else $error("Pointer moved in no-increment mode");
  a_ptr_inc_rw: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_data_access and func_r == pfl_pkg::FUNC_INC_RW |=> ptr_r == $past(ptr_r) + 16'h0001)
    else $error("Pointer not incremented after access");
  a_ptr_rd_keep: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    idata_rd && !mgmt_wr_i && func_r == pfl_pkg::FUNC_INC_WR |=> $stable(ptr_r))
    else $error("Pointer moved on read in write-increment mode");
  a_dev_sel_gate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    mgmt_wr_i && mgmt_addr_i == pfl_pkg::ADDR_IDATA && !win_ok |=> $stable(ptr_r))
    else $error("Window acted on foreign device select");
  a_ptr_read: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    idata_rd && func_r == pfl_pkg::FUNC_ADDR |=> mgmt_rvalid_o && mgmt_rdata_o == $past(ptr_r))
    else $error("Address mode read did not return pointer");
  a_ctrl_rsvd: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    mgmt_rd_i && mgmt_addr_i == pfl_pkg::ADDR_CTRL |=> mgmt_rdata_o[13:5] == 9'h000)
    else $error("Reserved control bits read nonzero");
  a_status_latch: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    |cause |=> ((status_r & $past(cause)) == $past(cause)) && link_drop_o)
    else $error("Drop cause not latched");
  a_status_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_status_read |=> status_r == $past(cause))
    else $error("Status not cleared to live causes on read");
  a_drop_follow: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    strap_r[pfl_pkg::STRAP_ENERGY_BIT] && lvl_s2_r[0] |=> link_drop_o)
    else $error("Energy loss did not drop link");
endmodule
`default_nettype wire

/* pfl_mgmt_regs_tb.sv */
/*
  Self-checking testbench for the management register slice.
  Assumes the host model drives the register port and that the fast
  link-down window runs free from the release of reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pfl_mgmt_regs_tb;
  logic sys_clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [4:0] addr;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rvalid;
  logic [2:0] ev = 3'h0;
  logic energy = 1'b0;
  logic descr = 1'b0;
  logic link_drop_o;
  logic bypass_4b5b_o;
  logic mirror_en_o;
  logic tx_sym4_o;
  logic err_pin;
  logic rx_line_o;
  logic tp_tx;
  logic rp_tx;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;

  always #5 sys_clk_i = ~sys_clk_i;
  always #24 link_clk_i = ~link_clk_i;
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
    end
  end

  pfl_host_model u_host (.sys_clk_i(sys_clk_i), .mgmt_addr_o(addr), .mgmt_wr_o(wr),
    .mgmt_rd_o(rd), .mgmt_wdata_o(wdata), .mgmt_rdata_i(rdata), .mgmt_rvalid_i(rvalid));

  pfl_mgmt_regs u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .link_clk_i(link_clk_i),
    .mgmt_addr_i(addr), .mgmt_wr_i(wr), .mgmt_rd_i(rd), .mgmt_wdata_i(wdata),
    .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rvalid), .rx_err_i(ev[0]), .mlt3_viol_i(ev[1]),
    .snr_low_i(ev[2]), .energy_loss_i(energy), .descr_unlock_i(descr),
    .link_drop_o(link_drop_o), .bypass_4b5b_o(bypass_4b5b_o), .mirror_en_o(mirror_en_o),
    .tdi_txd4_i(1'b1), .tx_sym4_o(tx_sym4_o), .rx_sym4_i(1'b1),
    .receive_error_pin_o(err_pin), .tx_line_i(1'b1), .rx_line_o(rx_line_o),
    .transmit_pair_tx_o(tp_tx), .receive_pair_tx_o(rp_tx), .transmit_pair_rx_i(1'b0),
    .receive_pair_rx_i(1'b1));

  // ==========================================================
  // Shared helpers
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    u_host.read_reg(a, d, ok);
    chk(16'(ok), 16'h0001);
    chk(d, exp);
  endtask

  task automatic wc(input logic [15:0] d);
    u_host.write_reg(pfl_pkg::ADDR_CTRL, d);
  endtask

  task automatic wa(input logic [15:0] d);
    u_host.write_reg(pfl_pkg::ADDR_IDATA, d);
  endtask

  task automatic ws(input logic [15:0] d);
    u_host.write_reg(pfl_pkg::ADDR_STRAP3, d);
  endtask

  task automatic wait_off(input int o);
    @(posedge sys_clk_i);
    while (cyc % pfl_pkg::WINDOW_CYC != o) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wait_drop();
    int i;
    for (i = 0; i < 20 && link_drop_o !== 1'b1; i++) @(posedge sys_clk_i);
    #1;
    chk(16'(link_drop_o), 16'h0001);
  endtask

  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      @(posedge link_clk_i);
      ev <= 3'(1 << sel);
      @(posedge link_clk_i);
      ev <= 3'h0;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_and_ctrl();
    rchk(pfl_pkg::ADDR_CTRL, 16'h0000);
    rchk(pfl_pkg::ADDR_IDATA, 16'h0000);
    rchk(pfl_pkg::ADDR_STATUS, 16'h0000);
    rchk(5'h05, 16'h0000);
    wc(16'hffff);
    rchk(pfl_pkg::ADDR_CTRL, 16'hc01f);
    ws(16'hffff);
    rchk(pfl_pkg::ADDR_STRAP3, 16'h047f);
  endtask

  task automatic t_window();
    u_host.open_window(pfl_pkg::FUNC_DATA, 16'h0002);
    wa(16'h1111);
    rchk(pfl_pkg::ADDR_IDATA, 16'h1111);
    rchk(pfl_pkg::ADDR_IDATA, 16'h1111);
    u_host.open_window(pfl_pkg::FUNC_INC_RW, 16'h0002);
    wa(16'h00a2);
    wa(16'h00a3);
    wc(16'h001f);
    rchk(pfl_pkg::ADDR_IDATA, 16'h0004);
    u_host.open_window(pfl_pkg::FUNC_INC_RW, 16'h0002);
    rchk(pfl_pkg::ADDR_IDATA, 16'h00a2);
    rchk(pfl_pkg::ADDR_IDATA, 16'h00a3);
    u_host.open_window(pfl_pkg::FUNC_INC_WR, 16'h0002);
    rchk(pfl_pkg::ADDR_IDATA, 16'h00a2);
    rchk(pfl_pkg::ADDR_IDATA, 16'h00a2);
    wa(16'h00b2);
    rchk(pfl_pkg::ADDR_IDATA, 16'h00a3);
    wc(16'h401e);
    wa(16'h5555);
    rchk(pfl_pkg::ADDR_IDATA, 16'h0000);
    wc(16'h001f);
    rchk(pfl_pkg::ADDR_IDATA, 16'h0003);
  endtask

  task automatic t_straps();
    logic [15:0] straps [4] = '{16'h0000, 16'h0020, 16'h0040, 16'h0070};
    logic [6:0] exp [4] = '{7'h60, 7'h10, 7'h60, 7'h1f};
    int k;
    for (k = 0; k < 4; k++) begin
      ws(straps[k]);
      repeat (6) @(posedge link_clk_i);
      #1;
      chk(16'({rx_line_o, tp_tx, rp_tx, err_pin, tx_sym4_o, bypass_4b5b_o, mirror_en_o}),
        16'(exp[k]));
    end
  endtask

  task automatic t_counters();
    int lim [3] = '{pfl_pkg::RX_ERR_LIMIT, pfl_pkg::MLT3_LIMIT, pfl_pkg::SNR_LIMIT};
    int k;
    for (k = 0; k < 3; k++) begin
      ws(16'(1 << (3 - k)));
      wait_off(50);
      pulse(k, lim[k] - 1);
      wait_off(990);
      chk(16'(link_drop_o), 16'h0000);
      wait_off(50);
      pulse(k, lim[k]);
      wait_drop();
      rchk(pfl_pkg::ADDR_STATUS, 16'(1 << (pfl_pkg::STATUS_LSB + 3 - k)));
      wait_off(10);
      rchk(pfl_pkg::ADDR_STATUS, 16'(1 << (pfl_pkg::STATUS_LSB + 3 - k)));
      rchk(pfl_pkg::ADDR_STATUS, 16'h0000);
    end
  endtask

  task automatic t_levels();
    ws(16'h0001);
    @(posedge link_clk_i);
    energy <= 1'b1;
    wait_drop();
    rchk(pfl_pkg::ADDR_STATUS, 16'h0010);
    @(posedge link_clk_i);
    energy <= 1'b0;
    repeat (12) @(posedge sys_clk_i);
    rchk(pfl_pkg::ADDR_STATUS, 16'h0010);
    rchk(pfl_pkg::ADDR_STATUS, 16'h0000);
    ws(16'h0000);
    @(posedge link_clk_i);
    descr <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    chk(16'(link_drop_o), 16'h0000);
    ws(16'h0401);
    wait_drop();
    rchk(pfl_pkg::ADDR_STATUS, 16'h0100);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (3) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_reset_and_ctrl();
    t_window();
    t_straps();
    t_counters();
    t_levels();
    conclude();
  end

  initial begin
    #400000;
    fails++;
    conclude();
  end
endmodule
`default_nettype wire

/* pfl_pkg.sv */
/*
  Constants for the management register slice: register offsets, field
  positions, reset values, indirect-window function codes and the
  fast link-down thresholds and timing.
  Assumes a 100 MHz system clock.
*/
package pfl_pkg;
  // ==========================================================
  // Register offsets on the management register port
  localparam logic [4:0] ADDR_STRAP3 = 5'h0b;
  localparam logic [4:0] ADDR_CTRL = 5'h0d;
  localparam logic [4:0] ADDR_IDATA = 5'h0e;
  localparam logic [4:0] ADDR_STATUS = 5'h0f;
  // ==========================================================
  // Reset values and writable masks
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hc01f;
  localparam logic [15:0] STRAP_WMASK = 16'h047f;
  // ==========================================================
  // Indirect control fields
  localparam int FUNC_LSB = 14;
  localparam logic [1:0] FUNC_ADDR = 2'h0;
  localparam logic [1:0] FUNC_DATA = 2'h1;
  localparam logic [1:0] FUNC_INC_RW = 2'h2;
  localparam logic [1:0] FUNC_INC_WR = 2'h3;
  localparam logic [4:0] SEL_VENDOR = 5'h1f;
  // ==========================================================
  // Software strap control three bit positions
  localparam int STRAP_DESCR_BIT = 10;
  localparam int STRAP_POL_BIT = 6;
  localparam int STRAP_SWAP_BIT = 5;
  localparam int STRAP_BYPASS_BIT = 4;
  localparam int STRAP_RX_ERR_BIT = 3;
  localparam int STRAP_MLT3_BIT = 2;
  localparam int STRAP_SNR_BIT = 1;
  localparam int STRAP_ENERGY_BIT = 0;
  // ==========================================================
  // Link-drop cause positions, status field position
  localparam int STATUS_LSB = 4;
  localparam int CAUSE_DESCR = 4;
  localparam int CAUSE_RX_ERR = 3;
  localparam int CAUSE_MLT3 = 2;
  localparam int CAUSE_SNR = 1;
  localparam int CAUSE_ENERGY = 0;
  // ==========================================================
  // Fast link-down counting
  localparam int WINDOW_NS = 10000;
  localparam int SYS_CLK_MHZ = 100;
  localparam int WINDOW_CYC = (WINDOW_NS * SYS_CLK_MHZ) / 1000;
  localparam logic [9:0] WINDOW_LAST = 10'(WINDOW_CYC - 1);
  localparam int RX_ERR_LIMIT = 32;
  localparam int MLT3_LIMIT = 20;
  localparam int SNR_LIMIT = 20;
  localparam int CNT_W = 6;
  // ==========================================================
  // Extended register storage
  localparam int EXT_IDX_W = 4;
  localparam int EXT_DEPTH = 16;
  localparam logic [15:0] EXT_DEPTH_W = 16'h0010;
endpackage
